// ---- logic/mon_seq_pkg.sv ----
package mon_seq_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_ADC_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_SHUNT_CAL = 4'h2;
  localparam logic [3:0] ADDR_VSHUNT = 4'h4;
  localparam logic [3:0] ADDR_VBUS = 4'h5;
  localparam logic [3:0] ADDR_DIETEMP = 4'h6;
  localparam logic [3:0] ADDR_CURRENT = 4'h7;
  localparam logic [3:0] ADDR_POWER = 4'h8;
  localparam logic [3:0] ADDR_ENERGY = 4'h9;
  localparam logic [3:0] ADDR_CHARGE = 4'hA;
  localparam logic [3:0] ADDR_DIAG = 4'hB;

  // Field positions
  localparam int DELAY_LSB = 6;
  localparam int DELAY_W = 8;
  localparam int DIAG_DONE_BIT = 1;
  localparam int DIAG_ACCUM_OK_BIT = 2;

  // Values after reset
  localparam logic [7:0] DELAY_RESET = 8'h00;
  localparam logic [15:0] ADC_CONFIG_RESET = 16'hFB68;
  localparam logic [14:0] SHUNT_CAL_RESET = 15'h0000;

  // Channels
  localparam logic [1:0] CH_SHUNT = 2'h0;
  localparam logic [1:0] CH_BUS = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int TICK_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int DELAY_STEP_MS = 2;
  localparam int DELAY_STEP_US = DELAY_STEP_MS * 1000;
  localparam int CT_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

  // Mode field: bit 15 continuous, bits 14:12 temp/bus/shunt enables
  typedef struct packed {
    logic continuous;
    logic [2:0] enable;
    logic [2:0] bus_ct;
    logic [2:0] shunt_ct;
    logic [2:0] temp_ct;
    logic [2:0] avg;
  } adc_cfg_s;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_DELAY,
    ST_CONV,
    ST_NEXT
  } seq_state_e;

endpackage

// ---- logic/us_timer.sv ----
`timescale 1ns/1ps
module us_timer #(
  parameter int W = 20
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [W-1:0] i_load,
  input wire logic i_tick,
  output logic o_busy,
  output logic o_done
);

  logic [W-1:0] cnt_q;

  // A zero load clears the count; used as abort
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cnt_q <= '0;
    else if (i_start)
      cnt_q <= i_load;
    else if (i_tick && cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  assign o_busy = (cnt_q != '0);
  // Done ignores start so a restart in the end cycle forms no loop
  assign o_done = i_tick && (cnt_q == W'(1));

  chk_done_after_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_done && !i_start |=> !o_busy)
    else $error("timer still busy after done");

endmodule

// ---- logic/avg_accum.sv ----
`timescale 1ns/1ps
module avg_accum #(
  parameter int DW = 20,
  parameter int SW = 10
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire logic i_add,
  input wire logic [DW-1:0] i_sample,
  input wire logic [3:0] i_shift,
  output logic [DW-1:0] o_mean
);

  logic signed [DW+SW-1:0] acc_q;
  logic signed [DW+SW-1:0] shifted;
  logic signed [DW+SW-1:0] sum;

  // Mean includes the sample added in this cycle, so the last one counts
  assign sum = i_add ? acc_q + (DW+SW)'($signed(i_sample)) : acc_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      acc_q <= '0;
    else if (i_clear)
      acc_q <= '0;
    else if (i_add)
      acc_q <= sum;
  end

  // Power-of-two counts let a shift stand in for a divider
  assign shifted = sum >>> i_shift;
  assign o_mean = shifted[DW-1:0];

endmodule

// ---- logic/monitor_adc_sequencer.sv ----
// Operation
// [R1] Only inputs enabled in the mode field are converted.
// [R2] Without averaging each result register updates at its own conversion end.
// [R3] Shunt, bus and temperature each use their own conversion time.
// [R4] Enabled inputs convert one after another.
// [R5] With averaging the sequence repeats; results written only after the count.
// [R6] Results hold until the next complete result; reads do not disturb.
// [R7] Continuous mode repeats the sequence forever, updating after each pass.
// [R8] Triggered mode runs one sequence then shuts down until a mode write.
// [R9] A mode write aborts the running conversion and restarts per new value.
// [R10] Done flag sets only after all conversions and averaging finish.
// [R11] Done flag clears on non-shutdown setup write or diagnostic read.
// [R12] Energy and charge are valid only in continuous mode.
// [R13] Arithmetic runs beside conversions, never lengthening them.
// [R14] Start delay 0 to 510 ms in 2 ms steps, reset to zero.
// [R15] Filter follows selected conversion time, settling within one period.
// [R16] Averaging count 1 to 1024 applies to every enabled input.
// [R17] Current and charge after shunt; power and energy after bus. The current and power registers update instead when the averaging count ends.
// [R18] Zero shunt calibration reports power, energy and charge as zero.
// [R19] Energy and charge accumulate per conversion, outside averaging.
// [R20] Start delay applies once after a mode write only.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module monitor_adc_sequencer #(
  parameter int TICK_CYCLES = mon_seq_pkg::TICK_CYCLES,
  parameter int DW = 20
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic [DW-1:0] I_ADC_DATA,
  output logic [1:0] O_ADC_CHANNEL,
  output logic [2:0] O_ADC_CT_CODE,
  output logic O_ADC_RUN,
  output logic O_ADC_RESTART
);

  localparam int TW = 20;

  mon_seq_pkg::adc_cfg_s cfg_q;
  logic [7:0] delay_q;
  logic [14:0] shunt_cal_q;
  logic [DW-1:0] res_q [3];
  logic [DW-1:0] current_q;
  logic [DW-1:0] power_q;
  logic [DW-1:0] current_now_q;
  logic [39:0] energy_q;
  logic [39:0] charge_q;
  logic done_flag_q;
  logic [31:0] rdata_q;
  logic [$clog2(TICK_CYCLES)-1:0] pre_q;
  logic tick;
  mon_seq_pkg::seq_state_e state_q;
  logic [1:0] ch_q;
  logic [10:0] avg_cnt_q;
  logic start_pending_q;
  logic mode_wr;
  logic diag_rd;
  logic conv_start;
  logic delay_start;
  logic conv_done;
  logic delay_done;
  logic delay_busy;
  logic last_ch;
  logic seq_end;
  logic avg_end;
  logic [1:0] next_ch;
  logic [1:0] first_ch;
  logic [3:0] shift;
  logic [10:0] avg_target;
  logic [DW-1:0] mean [3];
  logic [TW-1:0] ct_load;
  logic [TW-1:0] delay_load;
  logic signed [DW+15:0] cur_prod;
  logic signed [2*DW-1:0] pwr_prod;
  logic [DW-1:0] cur_calc;
  logic [DW-1:0] pwr_calc;
  logic signed [DW+15:0] avg_cur_prod;
  logic [DW-1:0] avg_cur;
  logic signed [2*DW-1:0] avg_pwr_prod;
  logic conv_end_raw;
  logic delay_end_raw;

  assign mode_wr = (I_WR && I_ADDR == mon_seq_pkg::ADDR_ADC_CONFIG) || start_pending_q;
  assign diag_rd = I_RD && I_ADDR == mon_seq_pkg::ADDR_DIAG;

  // Register writes
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      cfg_q <= mon_seq_pkg::ADC_CONFIG_RESET;
      delay_q <= mon_seq_pkg::DELAY_RESET; // [R14]
      shunt_cal_q <= mon_seq_pkg::SHUNT_CAL_RESET;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        mon_seq_pkg::ADDR_CONFIG:
          delay_q <= I_WDATA[mon_seq_pkg::DELAY_LSB +: mon_seq_pkg::DELAY_W];
        mon_seq_pkg::ADDR_ADC_CONFIG:
          cfg_q <= I_WDATA[15:0];
        mon_seq_pkg::ADDR_SHUNT_CAL:
          shunt_cal_q <= I_WDATA[14:0];
        default:
          ;
      endcase
    end
  end

  // Reset behaves like a mode write of the reset value
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      start_pending_q <= 1'b1;
    else
      start_pending_q <= 1'b0;
  end

  // Free-running microsecond tick; conversions may run up to one tick short
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      pre_q <= '0;
    else if (tick)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end
  assign tick = (pre_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

  // Channel ordering: shunt, bus, temperature
  always_comb
  begin
    first_ch = mon_seq_pkg::CH_SHUNT;
    if (!cfg_q.enable[0])
      first_ch = cfg_q.enable[1] ? mon_seq_pkg::CH_BUS : mon_seq_pkg::CH_TEMP;
    next_ch = first_ch;
    last_ch = 1'b1;
    if (ch_q == mon_seq_pkg::CH_SHUNT && cfg_q.enable[1])
    begin
      next_ch = mon_seq_pkg::CH_BUS; // [R4]
      last_ch = 1'b0;
    end
    else if (ch_q != mon_seq_pkg::CH_TEMP && cfg_q.enable[2])
    begin
      next_ch = mon_seq_pkg::CH_TEMP; // [R4]
      last_ch = 1'b0;
    end
  end

  // Per-input conversion time
  always_comb
  begin
    case (ch_q)
      mon_seq_pkg::CH_SHUNT: O_ADC_CT_CODE = cfg_q.shunt_ct; // [R3]
      mon_seq_pkg::CH_BUS: O_ADC_CT_CODE = cfg_q.bus_ct; // [R3]
      default: O_ADC_CT_CODE = cfg_q.temp_ct; // [R3]
    endcase
  end

  assign shift = 4'(mon_seq_pkg::AVG_SHIFT[cfg_q.avg]);
  assign avg_target = 11'(1 << shift); // [R16]
  assign delay_load = TW'(delay_q * mon_seq_pkg::DELAY_STEP_US); // [R14]
  assign seq_end = conv_done && last_ch;
  assign avg_end = seq_end && (avg_cnt_q + 11'd1 == avg_target); // [R5]

  // Start next conversion: after delay, after each channel, or straight after a mode write when the delay is zero
  assign delay_start = mode_wr;
  // A mode write in the end cycle aborts: no sample, no next step
  assign conv_done = conv_end_raw && !mode_wr; // [R9]
  assign delay_done = delay_end_raw && !mode_wr; // [R9]
  assign conv_start = (state_q == mon_seq_pkg::ST_DELAY && delay_done)
    || (mode_wr && cfg_q_next_enable_nz() && delay_q_next_zero())
    || (conv_done && !(avg_end && !cfg_q.continuous)); // [R7]

  function automatic logic cfg_q_next_enable_nz();
    if (I_WR && I_ADDR == mon_seq_pkg::ADDR_ADC_CONFIG)
      return I_WDATA[14:12] != 3'b000;
    return cfg_q.enable != 3'b000;
  endfunction

  function automatic logic delay_q_next_zero();
    if (I_WR && I_ADDR == mon_seq_pkg::ADDR_CONFIG)
      return I_WDATA[mon_seq_pkg::DELAY_LSB +: mon_seq_pkg::DELAY_W] == 8'h00;
    return delay_q == 8'h00;
  endfunction

  // Conversion time in microseconds for the channel about to start
  always_comb
  begin
    mon_seq_pkg::adc_cfg_s c;
    logic [1:0] ch;
    c = (I_WR && I_ADDR == mon_seq_pkg::ADDR_ADC_CONFIG) ? I_WDATA[15:0] : cfg_q;
    ch = (state_q == mon_seq_pkg::ST_CONV && !mode_wr) ? next_ch : first_ch;
    if (mode_wr && !c.enable[0])
      ch = c.enable[1] ? mon_seq_pkg::CH_BUS : mon_seq_pkg::CH_TEMP;
    else if (mode_wr)
      ch = mon_seq_pkg::CH_SHUNT;
    if (conv_done && last_ch && !mode_wr)
      ch = first_ch;
    case (ch)
      mon_seq_pkg::CH_SHUNT: ct_load = TW'(mon_seq_pkg::CT_US[c.shunt_ct]);
      mon_seq_pkg::CH_BUS: ct_load = TW'(mon_seq_pkg::CT_US[c.bus_ct]);
      default: ct_load = TW'(mon_seq_pkg::CT_US[c.temp_ct]);
    endcase
  end

  // Abort on mode write by loading zero when nothing new starts
  us_timer #(.W(TW)) u_conv_timer (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_start(conv_start || mode_wr), // [R9]
    .i_load(conv_start ? ct_load : TW'(0)),
    .i_tick(tick),
    .o_busy(),
    .o_done(conv_end_raw)
  );

  us_timer #(.W(TW)) u_delay_timer (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_start(delay_start), // [R20]
    .i_load(delay_load),
    .i_tick(tick),
    .o_busy(delay_busy),
    .o_done(delay_end_raw)
  );

  // Sequencer state
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      state_q <= mon_seq_pkg::ST_OFF;
      ch_q <= mon_seq_pkg::CH_SHUNT;
    end
    else if (mode_wr)
    begin
      if (!cfg_q_next_enable_nz())
        state_q <= mon_seq_pkg::ST_OFF; // [R9]
      else if (conv_start)
        state_q <= mon_seq_pkg::ST_CONV; // [R9]
      else
        state_q <= mon_seq_pkg::ST_DELAY; // [R14]
      if (I_WR && I_ADDR == mon_seq_pkg::ADDR_ADC_CONFIG)
        ch_q <= I_WDATA[12] ? mon_seq_pkg::CH_SHUNT
          : (I_WDATA[13] ? mon_seq_pkg::CH_BUS : mon_seq_pkg::CH_TEMP); // [R1]
      else
        ch_q <= first_ch;
    end
    else
    begin
      case (state_q)
        mon_seq_pkg::ST_DELAY:
          if (delay_done)
            state_q <= mon_seq_pkg::ST_CONV;
        mon_seq_pkg::ST_CONV:
          if (avg_end && !cfg_q.continuous)
            state_q <= mon_seq_pkg::ST_OFF; // [R8]
        default:
          state_q <= state_q;
      endcase
      if (conv_start)
        ch_q <= (state_q == mon_seq_pkg::ST_CONV && !last_ch) ? next_ch : first_ch; // [R1]
    end
  end

  // Averaging pass counter
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      avg_cnt_q <= '0;
    else if (mode_wr || avg_end)
      avg_cnt_q <= '0;
    else if (seq_end)
      avg_cnt_q <= avg_cnt_q + 11'd1; // [R5]
  end

  for (genvar g = 0; g < 3; g++)
  begin : g_avg
    avg_accum #(.DW(DW), .SW(10)) u_acc (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_clear(mode_wr || avg_end), // [R5]
      .i_add(conv_done && ch_q == 2'(g)),
      .i_sample(I_ADC_DATA),
      .i_shift(shift),
      .o_mean(mean[g])
    );

    // Results only change on a finished conversion or finished average
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
      if (!I_RESET_N)
        res_q[g] <= '0;
      else if (shift == 4'd0 && conv_done && ch_q == 2'(g))
        res_q[g] <= I_ADC_DATA; // [R2] [R6]
      else if (shift != 4'd0 && avg_end && cfg_q.enable[g])
        res_q[g] <= (ch_q == 2'(g)) ? 
          mean[g]
          : mean[g]; // [R5] [R6]
    end
  end

  // Background arithmetic, never stalls the sequencer
  assign cur_prod = $signed(I_ADC_DATA) * $signed({1'b0, shunt_cal_q});
  assign cur_calc = (shunt_cal_q == 15'h0000) ? '0 : cur_prod[DW+10:11];
  assign pwr_prod = $signed(current_now_q) * $signed(I_ADC_DATA);
  assign pwr_calc = (shunt_cal_q == 15'h0000) ? '0 : pwr_prod[2*DW-1:DW]; // [R18]

  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      current_now_q <= '0;
      charge_q <= '0;
      energy_q <= '0;
    end
    else if (shunt_cal_q == 15'h0000)
    begin
      charge_q <= '0; // [R18]
      energy_q <= '0; // [R18]
      current_now_q <= '0;
    end
    else if (conv_done && ch_q == mon_seq_pkg::CH_SHUNT)
    begin
      current_now_q <= cur_calc; // [R17] [R13]
      charge_q <= charge_q + 40'($signed(cur_calc)); // [R19]
    end
    else if (conv_done && ch_q == mon_seq_pkg::CH_BUS)
      energy_q <= energy_q + 40'($signed(pwr_calc)); // [R17] [R19]
  end

  // Current and power outputs follow the averaged shunt and bus results
  assign avg_cur_prod = $signed(mean[0]) * $signed({1'b0, shunt_cal_q});
  assign avg_cur = avg_cur_prod[DW+10:11];
  assign avg_pwr_prod = $signed(avg_cur) * $signed(mean[1]);

  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      current_q <= '0;
      power_q <= '0;
    end
    else if (shunt_cal_q == 15'h0000)
    begin
      current_q <= '0;
      power_q <= '0; // [R18]
    end
    else if (seq_end && (shift == 4'd0 || avg_end))
    begin
      current_q <= avg_cur; // [R17]
      power_q <= avg_pwr_prod[2*DW-1:DW]; // [R17]
    end
  end

  // Done flag: a set in the clearing cycle wins
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      done_flag_q <= 1'b0;
    else if (avg_end)
      done_flag_q <= 1'b1; // [R10]
    else if (diag_rd || (I_WR && I_ADDR == mon_seq_pkg::ADDR_ADC_CONFIG
      && I_WDATA[14:12] != 3'b000))
      done_flag_q <= 1'b0; // [R11]
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      rdata_q <= '0;
    else if (I_RD)
    begin
      case (I_ADDR)
        mon_seq_pkg::ADDR_CONFIG: rdata_q <= 32'({delay_q, 6'b00_0000});
        mon_seq_pkg::ADDR_ADC_CONFIG: rdata_q <= 32'(cfg_q);
        mon_seq_pkg::ADDR_SHUNT_CAL: rdata_q <= 32'(shunt_cal_q);
        mon_seq_pkg::ADDR_VSHUNT: rdata_q <= 32'(res_q[0]); // [R6]
        mon_seq_pkg::ADDR_VBUS: rdata_q <= 32'(res_q[1]);
        mon_seq_pkg::ADDR_DIETEMP: rdata_q <= 32'(res_q[2]);
        mon_seq_pkg::ADDR_CURRENT: rdata_q <= 32'(current_q);
        mon_seq_pkg::ADDR_POWER: rdata_q <= 32'(power_q);
        mon_seq_pkg::ADDR_ENERGY: rdata_q <= energy_q[39:8];
        mon_seq_pkg::ADDR_CHARGE: rdata_q <= charge_q[39:8];
        mon_seq_pkg::ADDR_DIAG:
          rdata_q <= 32'({cfg_q.continuous, done_flag_q, 1'b0}); // [R12]
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else
      rdata_q <= 32'h0000_0000;
  end

  assign O_RDATA = rdata_q;
  assign O_ADC_CHANNEL = ch_q;
  assign O_ADC_RUN = (state_q == mon_seq_pkg::ST_CONV);
  // Filter restarts per conversion so it settles inside one period
  assign O_ADC_RESTART = conv_start; // [R15]

  sequence s_last_conv;
    state_q == mon_seq_pkg::ST_CONV && avg_end;
  endsequence

  chk_mode_abort: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R9]
    (I_WR && I_ADDR == mon_seq_pkg::ADDR_ADC_CONFIG && I_WDATA[14:12] == 3'b000)
    |=> state_q == mon_seq_pkg::ST_OFF)
    else $error("mode write to shutdown did not stop");
  chk_done_set_cause: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R10]
    $rose(done_flag_q) |-> $past(avg_end))
    else $error("done flag set without finished sequence");
  chk_done_clear: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R11]
    diag_rd && !avg_end |=> !done_flag_q)
    else $error("diagnostic read did not clear done flag");
  chk_trig_shutdown: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R8]
    s_last_conv and !cfg_q.continuous && !mode_wr |=> state_q == mon_seq_pkg::ST_OFF)
    else $error("triggered mode did not shut down");
  chk_cont_repeat: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R7]
    s_last_conv and cfg_q.continuous && !mode_wr |=> state_q == mon_seq_pkg::ST_CONV
    && !delay_busy)
    else $error("continuous mode did not repeat at once");
  chk_channel_enabled: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R1]
    O_ADC_RUN |-> cfg_q.enable[ch_q])
    else $error("disabled input is being converted");
  chk_result_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R6]
    !conv_done |=> $stable(res_q[1]))
    else $error("result changed without a conversion end");
  chk_cal_zero: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R18]
    shunt_cal_q == 15'h0000 |=> power_q == '0 && charge_q == '0)
    else $error("power or charge nonzero with zero calibration");
  chk_avg_count: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [R16]
    seq_end && !mode_wr |-> (avg_end == (avg_cnt_q == avg_target - 11'd1)))
    else $error("averaging count mismatch");

endmodule

// ---- testbench/monitor_adc_sequencer_bench.sv ----
`timescale 1ns/1ps
module monitor_adc_sequencer_bench;
  // Short microsecond tick keeps the long conversion times affordable
  localparam int T = 2;
  logic I_CLK, I_RESET_N, I_WR, I_RD, O_ADC_RUN, O_ADC_RESTART, rs_q;
  logic [3:0] I_ADDR;
  logic [31:0] I_WDATA, O_RDATA, rv;
  logic [19:0] I_ADC_DATA, sh_val, prev;
  logic [1:0] O_ADC_CHANNEL;
  logic [2:0] O_ADC_CT_CODE;
  int cyc = 0, wcyc, w0, failures = 0, tests_run = 0, n;
  int st[$];
  logic [1:0] ch[$];

  monitor_adc_sequencer #(.TICK_CYCLES(T), .DW(20)) dut_u (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_ADC_DATA(I_ADC_DATA),
    .O_ADC_CHANNEL(O_ADC_CHANNEL), .O_ADC_CT_CODE(O_ADC_CT_CODE),
    .O_ADC_RUN(O_ADC_RUN), .O_ADC_RESTART(O_ADC_RESTART));

  initial
  begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end

  // Restart times and the channel shown one cycle later
  always @(posedge I_CLK)
  begin
    cyc <= cyc + 1;
    if (rs_q)
      ch.push_back(O_ADC_CHANNEL);
    if (O_ADC_RESTART === 1'b1)
      st.push_back(cyc);
    rs_q <= (O_ADC_RESTART === 1'b1);
    if (O_ADC_CHANNEL == mon_seq_pkg::CH_BUS)
      I_ADC_DATA <= 20'h0_2000;
    else if (O_ADC_CHANNEL == mon_seq_pkg::CH_TEMP)
      I_ADC_DATA <= 20'h0_0155;
    else
      I_ADC_DATA <= sh_val;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int v);
    tests_run++;
    if (v < lo || v > hi)
    begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    wcyc = cyc;
    I_WR <= 1'b0;
    #1;
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(nm, e, O_RDATA);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge I_CLK);
  endtask

  // Restart spacing; the prescaler may cut one tick short
  task automatic gap(input int i, input int code);
    int e;
    e = mon_seq_pkg::CT_US[code] * T;
    chk_rng("restart gap", e - T, e + 2, (st.size() > i + 1) ? st[i+1] - st[i] : -1);
  endtask

  function automatic logic [31:0] cfg(input logic c, input logic [2:0] en,
    input logic [2:0] b, input logic [2:0] s, input logic [2:0] t, input logic [2:0] a);
    mon_seq_pkg::adc_cfg_s v;
    v = '{c, en, b, s, t, a};
    return {16'h0000, v};
  endfunction

  task automatic go(input logic [31:0] c);
    wr(mon_seq_pkg::ADDR_ADC_CONFIG, c);
    // Drop restarts of the run that the write cut off
    while (st.size() > 0 && st[0] < wcyc)
      void'(st.pop_front());
    ch.delete();
  endtask

  task automatic wrap_up();
    $display("Checks run: %0d, mismatches: %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(80000 * 4);
    failures++;
    wrap_up();
  end

  initial
  begin
    I_RESET_N = 1'b0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_ADDR = 4'h0;
    I_WDATA = 32'h0000_0000;
    I_ADC_DATA = 20'h0_0000;
    sh_val = 20'h0_1000;
    rs_q = 1'b0;
    idle(3);
    I_RESET_N <= 1'b1;
    rchk("config", mon_seq_pkg::ADDR_CONFIG, 32'h0000_0000);
    rchk("adc_config", mon_seq_pkg::ADDR_ADC_CONFIG, 32'h0000_FB68);
    rchk("shunt_cal", mon_seq_pkg::ADDR_SHUNT_CAL, 32'h0000_0000);
    wr(4'h3, 32'hFFFF_FFFF);
    rchk("unmapped", 4'h3, 32'h0000_0000);
    // Zero calibration blanks the derived values
    go(cfg(1'b1, 3'b011, 3'd0, 3'd0, 3'd0, 3'd0));
    idle(500);
    rchk("power", mon_seq_pkg::ADDR_POWER, 32'h0000_0000);
    rchk("energy", mon_seq_pkg::ADDR_ENERGY, 32'h0000_0000);
    rchk("charge", mon_seq_pkg::ADDR_CHARGE, 32'h0000_0000);
    wr(mon_seq_pkg::ADDR_SHUNT_CAL, 32'h0000_0800);
    // One triggered pass over all three inputs
    go(cfg(1'b0, 3'b111, 3'd1, 3'd0, 3'd2, 3'd0));
    idle(700);
    chk("restarts", 32'd3, 32'(st.size()));
    chk("run", 32'd0, 32'(O_ADC_RUN));
    chk("ch0", 32'(mon_seq_pkg::CH_SHUNT), 32'(ch[0]));
    chk("ch1", 32'(mon_seq_pkg::CH_BUS), 32'(ch[1]));
    chk("ch2", 32'(mon_seq_pkg::CH_TEMP), 32'(ch[2]));
    gap(0, 0);
    gap(1, 1);
    rchk("vshunt", mon_seq_pkg::ADDR_VSHUNT, 32'h0000_1000);
    rchk("vbus", mon_seq_pkg::ADDR_VBUS, 32'h0000_2000);
    rchk("dietemp", mon_seq_pkg::ADDR_DIETEMP, 32'h0000_0155);
    rchk("current", mon_seq_pkg::ADDR_CURRENT, 32'h0000_1000);
    rchk("power", mon_seq_pkg::ADDR_POWER, 32'h0000_0020);
    rchk("diag", mon_seq_pkg::ADDR_DIAG, 32'h0000_0002);
    // Every conversion time code on the bus input
    for (int k = 0; k < 8; k++)
    begin
      go(cfg(1'b0, 3'b110, k[2:0], 3'd0, 3'd0, 3'd0));
      idle(mon_seq_pkg::CT_US[k] * T + 350);
      chk("restarts", 32'd2, 32'(st.size()));
      chk("ch0", 32'(mon_seq_pkg::CH_BUS), 32'(ch[0]));
      chk("ch1", 32'(mon_seq_pkg::CH_TEMP), 32'(ch[1]));
      gap(0, k);
    end
    // Averaging counts; outputs hold until the whole count is done
    prev = 20'h0_1000;
    for (int k = 0; k < 4; k++)
    begin
      n = 1 << mon_seq_pkg::AVG_SHIFT[k];
      sh_val = 20'h0_0800 + 20'(k);
      go(cfg(1'b0, 3'b001, 3'd0, 3'd0, 3'd0, k[2:0]));
      if (k > 0)
      begin
        idle(150);
        rchk("vshunt hold", mon_seq_pkg::ADDR_VSHUNT, {12'h000, prev});
      end
      idle(n * 100 + 100);
      chk("avg count", 32'(n), 32'(st.size()));
      if (n > 1)
        gap(n - 2, 0);
      rchk("vshunt", mon_seq_pkg::ADDR_VSHUNT, {12'h000, sh_val});
      prev = sh_val;
    end
    // Done flag: set, cleared by setup write and by diagnostic read
    go(cfg(1'b0, 3'b001, 3'd0, 3'd0, 3'd0, 3'd0));
    rchk("diag", mon_seq_pkg::ADDR_DIAG, 32'h0000_0000);
    idle(150);
    wr(mon_seq_pkg::ADDR_ADC_CONFIG, 32'h0000_0000);
    rchk("diag", mon_seq_pkg::ADDR_DIAG, 32'h0000_0002);
    rchk("diag", mon_seq_pkg::ADDR_DIAG, 32'h0000_0000);
    // Abort a long conversion with a continuous bus-only mode write
    go(cfg(1'b0, 3'b001, 3'd0, 3'd7, 3'd0, 3'd0));
    idle(500);
    wr(mon_seq_pkg::ADDR_ADC_CONFIG, cfg(1'b1, 3'b010, 3'd0, 3'd0, 3'd0, 3'd0));
    chk("restarts", 32'd2, 32'(st.size()));
    chk("abort edge", 32'(wcyc), 32'(st[1]));
    idle(450);
    chk("ch", 32'(mon_seq_pkg::CH_BUS), 32'(ch[1]));
    gap(1, 0);
    gap(2, 0);
    rchk("diag", mon_seq_pkg::ADDR_DIAG, 32'h0000_0006);
    // Start delay of one step, applied only before the first pass
    wr(mon_seq_pkg::ADDR_CONFIG, 32'h0000_0040);
    rchk("config", mon_seq_pkg::ADDR_CONFIG, 32'h0000_0040);
    go(cfg(1'b1, 3'b001, 3'd0, 3'd0, 3'd0, 3'd0));
    w0 = wcyc;
    idle(4350);
    chk_rng("delay", 4000 - T, 4003, (st.size() > 0) ? st[0] - w0 : -1);
    gap(0, 0);
    gap(1, 0);
    wrap_up();
  end
endmodule
